//--- core/flash_status_regs.svh
// constants for the flash status polling controller
`ifndef FLASH_STATUS_REGS_SVH
`define FLASH_STATUS_REGS_SVH
// ============================================================
// register offsets (byte addresses on the ahb-lite slave)
`define FS_CTRL_OFF      8'h00
`define FS_ADDR_OFF      8'h04
`define FS_DATA_OFF      8'h08
`define FS_STATUS_OFF    8'h0C
`define FS_RESULT_OFF    8'h10
// ============================================================
// control fields
`define FS_CTRL_START    0
`define FS_CTRL_MODE     1
`define FS_CTRL_METHOD   2
// ============================================================
// status fields
`define FS_ST_BUSY       0
`define FS_ST_DONE       1
`define FS_ST_FAIL       2
`define FS_ST_SUSP       3
`define FS_ST_RB         4
`define FS_ST_WINDOW     5
// ============================================================
// data bit positions on the flash data bus
`define FS_POLL_BIT      7
`define FS_TOG1_BIT      6
`define FS_TIMEOUT_BIT   5
`define FS_WINDOW_BIT    3
`define FS_TOG2_BIT      2
// ============================================================
// timing: clock period, read strobe and gap lengths in ns and derived cycles
`define FS_CLK_NS        5
`define FS_RD_NS         90
`define FS_RD_CYC        ((`FS_RD_NS + `FS_CLK_NS - 1) / `FS_CLK_NS)
`define FS_GAP_NS        20
`define FS_GAP_CYC       ((`FS_GAP_NS + `FS_CLK_NS - 1) / `FS_CLK_NS)
`endif

//--- core/flash_status_pkg.sv
// types shared by the flash status polling controller
package flash_status_pkg;
  // ============================================================
  // flash parallel bus pins seen from the controller
  typedef struct packed {
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic [20:0] addr;
  } flash_pins_s;
  // ============================================================
  // polling method
  typedef enum logic [1:0] {
    M_IDLE,
    M_POLL,
    M_TOGGLE
  } method_e;
endpackage : flash_status_pkg

//--- core/flash_read_cycle.sv
// one flash read cycle: chip select and output enable pulse, data sampled at end
`include "flash_status_regs.svh"
module flash_read_cycle #(
  parameter int RD_CYC  = `FS_RD_CYC,
  parameter int GAP_CYC = `FS_GAP_CYC
) (
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       rst_n_i,
  // request
  input  wire logic       go_i,
  output logic            busy_o,
  output logic            done_o,
  output logic [7:0]      data_o,
  // flash strobes and data
  output logic            ce_n_o,
  output logic            oe_n_o,
  input  wire logic [7:0] dq_i
);
  typedef enum logic [1:0] {
    S_IDLE,
    S_READ,
    S_GAP
  } rd_state_e;

  typedef struct packed {
    rd_state_e  st;
    logic [7:0] cnt;
    logic       done;
    logic [7:0] data;
    logic       ce_n;
    logic       oe_n;
  } rd_s;

  rd_s state_reg;
  rd_s state_next;

  // ============================================================
  // next state
  always_comb
  begin
    state_next      = state_reg;
    state_next.done = 1'b0;
    unique case (state_reg.st)
      S_IDLE:
      begin
        if (go_i)
        begin
          state_next.st   = S_READ;
          state_next.cnt  = 8'(RD_CYC - 1);
          state_next.ce_n = 1'b0;
          state_next.oe_n = 1'b0;
        end
      end
      S_READ:
      begin
        if (state_reg.cnt == 8'h00)
        begin
          // sample at end of strobe; each read ends fully so toggle bits advance once
          state_next.data = dq_i;
          state_next.ce_n = 1'b1;
          state_next.oe_n = 1'b1;
          state_next.st   = S_GAP;
          state_next.cnt  = 8'(GAP_CYC - 1);
        end
        else
        begin
          state_next.cnt = state_reg.cnt - 8'h01;
        end
      end
      S_GAP:
      begin
        if (state_reg.cnt == 8'h00)
        begin
          state_next.st   = S_IDLE;
          state_next.done = 1'b1;
        end
        else
        begin
          state_next.cnt = state_reg.cnt - 8'h01;
        end
      end
    endcase
  end

  // ============================================================
  // state register
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_reg <= '{st: S_IDLE, cnt: 8'h00, done: 1'b0, data: 8'h00, ce_n: 1'b1, oe_n: 1'b1};
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign busy_o = (state_reg.st != S_IDLE);
  assign done_o = state_reg.done;
  assign data_o = state_reg.data;
  assign ce_n_o = state_reg.ce_n;
  assign oe_n_o = state_reg.oe_n;
endmodule : flash_read_cycle

//--- core/flash_status_poller.sv
// host-side controller that polls flash write status over an ahb-lite register slave
//
// How it works
// RL1: status read only after command finished
// RL2: poll bit inverted until program done
// RL3: same polling for erase-suspended program
// RL4: program polls read at program address
// RL5: protected program: short polling then data
// RL6: erase poll bit low, high when done
// RL7: erase polls read inside selected sector
// RL8: all-protected erase: long polling then data
// RL9: after poll true, reread for data
// RL10: open-drain ready pin sampled as level
// RL11: ready pin low means busy
// RL12: first toggle bit flips each read
// RL13: toggle valid right after last write
// RL14: all-protected erase toggles then stops
// RL15: protected program toggles briefly then stops
// RL16: toggle stops in suspend, resumes programming
// RL17: second toggle flips in erasing sectors
// RL18: second toggle valid after last write
// RL19: two reads compared to judge toggling
// RL20: timeout high: recheck, still toggling fails
// RL21: timeout flag means failure, reset needed
// RL22: erase window flag sampled into status
// RL23: reads are whole cycles, never merged
`include "flash_status_regs.svh"
module flash_status_poller #(
  parameter int RD_CYC  = `FS_RD_CYC,
  parameter int GAP_CYC = `FS_GAP_CYC
) (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  // ahb-lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic [31:0]      hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // flash pins
  output logic             ce_n_o,
  output logic             oe_n_o,
  output logic             we_n_o,
  output logic [20:0]      addr_o,
  input  wire logic [7:0]  dq_i,
  input  wire logic        ready_busy_n_i
);
  typedef enum logic [2:0] {
    P_IDLE,
    P_FIRST,
    P_CHECK,
    P_RECHECK,
    P_FINAL
  } poll_state_e;

  typedef struct packed {
    poll_state_e               st;
    flash_status_pkg::method_e method;
    logic                      erase;
    logic [20:0]               addr;
    logic [7:0]                expect_d;
    logic [7:0]                last;
    logic [7:0]                result;
    logic                      busy;
    logic                      done;
    logic                      fail;
    logic                      susp;
    logic                      window;
    logic                      rb;
    logic                      go;
    logic                      ahb_wr;
    logic [7:0]                ahb_addr;
    logic [31:0]               rdata;
  } ctl_s;

  ctl_s state_reg;
  ctl_s state_next;

  logic       rd_busy;
  logic       rd_done;
  logic [7:0] rd_data;
  logic       rd_ce_n;
  logic       rd_oe_n;

  // ============================================================
  // read cycle engine
  flash_read_cycle #(
    .RD_CYC  (RD_CYC),
    .GAP_CYC (GAP_CYC)
  ) u_read (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .go_i    (state_reg.go),
    .busy_o  (rd_busy),
    .done_o  (rd_done),
    .data_o  (rd_data),
    .ce_n_o  (rd_ce_n),
    .oe_n_o  (rd_oe_n),
    .dq_i    (dq_i)
  );

  // true when the sampled byte shows the operation has finished
  function automatic logic poll_done(input logic [7:0] d, input logic er, input logic [7:0] ex);
    if (er)
      poll_done = d[`FS_POLL_BIT];                      // RL6
    else
      poll_done = (d[`FS_POLL_BIT] == ex[`FS_POLL_BIT]); // RL2
  endfunction : poll_done

  // true when the first toggle bit differs between two reads
  function automatic logic toggling(input logic [7:0] a, input logic [7:0] b);
    toggling = (a[`FS_TOG1_BIT] != b[`FS_TOG1_BIT]); // RL12
  endfunction : toggling

  // ============================================================
  // next state: ahb slave and polling sequencer
  always_comb
  begin
    state_next      = state_reg;
    state_next.go   = 1'b0;
    state_next.rb   = ready_busy_n_i; // RL10 RL11
    // address phase capture
    state_next.ahb_wr = 1'b0;
    if (hsel_i && hready_i && htrans_i[1])
    begin
      state_next.ahb_wr   = hwrite_i;
      state_next.ahb_addr = haddr_i[7:0];
      unique case (haddr_i[7:0])
        `FS_CTRL_OFF:   state_next.rdata = {29'h0000_0000, 1'b0, state_reg.erase, 1'b0};
        `FS_ADDR_OFF:   state_next.rdata = {11'h000, state_reg.addr};
        `FS_DATA_OFF:   state_next.rdata = {24'h00_0000, state_reg.expect_d};
        `FS_STATUS_OFF: state_next.rdata = {26'h000_0000, state_reg.window, state_reg.rb,
                                            state_reg.susp, state_reg.fail, state_reg.done, state_reg.busy};
        `FS_RESULT_OFF: state_next.rdata = {16'h0000, state_reg.last, state_reg.result};
        default:        state_next.rdata = 32'h0000_0000;
      endcase
    end
    // data phase write
    if (state_reg.ahb_wr)
    begin
      unique case (state_reg.ahb_addr)
        `FS_ADDR_OFF: state_next.addr = hwdata_i[20:0];     // RL4 RL7
        `FS_DATA_OFF: state_next.expect_d = hwdata_i[7:0];
        `FS_CTRL_OFF:
        begin
          if (hwdata_i[`FS_CTRL_START] && !state_reg.busy)
          begin
            // software starts only after its last write strobe: RL1 RL13 RL18
            state_next.erase  = hwdata_i[`FS_CTRL_MODE];
            state_next.method = hwdata_i[`FS_CTRL_METHOD] ? flash_status_pkg::M_TOGGLE
                                                          : flash_status_pkg::M_POLL;
            state_next.busy   = 1'b1;
            state_next.done   = 1'b0;
            state_next.fail   = 1'b0;
            state_next.susp   = 1'b0;
            state_next.st     = P_FIRST;
            state_next.go     = 1'b1;
          end
        end
        default: ;
      endcase
    end
    // polling sequencer
    unique case (state_reg.st)
      P_IDLE: ;
      P_FIRST:
      begin
        if (rd_done)
        begin
          state_next.last   = rd_data;
          state_next.window = rd_data[`FS_WINDOW_BIT]; // RL22
          if (state_reg.method == flash_status_pkg::M_POLL &&
              poll_done(rd_data, state_reg.erase, state_reg.expect_d))
            state_next.st = P_FINAL; // RL9 RL5 RL8 RL3
          else if (state_reg.method == flash_status_pkg::M_POLL && rd_data[`FS_TIMEOUT_BIT])
            state_next.st = P_RECHECK; // RL21
          else if (state_reg.method == flash_status_pkg::M_POLL)
            state_next.st = P_FIRST;
          else
            state_next.st = P_CHECK; // RL19
          state_next.go = 1'b1;
        end
      end
      P_CHECK:
      begin
        if (rd_done)
        begin
          state_next.last   = rd_data;
          state_next.window = rd_data[`FS_WINDOW_BIT];
          // second toggle still flipping while first stops means suspended erase: RL16 RL17
          state_next.susp   = state_reg.erase && !toggling(rd_data, state_reg.last) &&
                              (rd_data[`FS_TOG2_BIT] != state_reg.last[`FS_TOG2_BIT]);
          if (!toggling(rd_data, state_reg.last))
          begin
            state_next.st = P_FINAL; // RL14 RL15 RL23
            state_next.go = 1'b1;
          end
          else if (rd_data[`FS_TIMEOUT_BIT])
          begin
            state_next.st = P_RECHECK; // RL20
            state_next.go = 1'b1;
          end
          else
          begin
            state_next.go = 1'b1;
          end
        end
      end
      P_RECHECK:
      begin
        if (rd_done)
        begin
          if ((state_reg.method == flash_status_pkg::M_TOGGLE && toggling(rd_data, state_reg.last)) ||
              (state_reg.method == flash_status_pkg::M_POLL &&
               !poll_done(rd_data, state_reg.erase, state_reg.expect_d)))
          begin
            state_next.fail = 1'b1; // RL20 RL21
            state_next.busy = 1'b0;
            state_next.done = 1'b1;
            state_next.st   = P_IDLE;
          end
          else
          begin
            state_next.st = P_FINAL;
            state_next.go = 1'b1;
          end
          state_next.last = rd_data;
        end
      end
      P_FINAL:
      begin
        if (rd_done)
        begin
          state_next.result = rd_data; // RL9
          state_next.busy   = 1'b0;
          state_next.done   = 1'b1;
          state_next.st     = P_IDLE;
        end
      end
      default: state_next.st = P_IDLE;
    endcase
  end

  // ============================================================
  // state register
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_reg <= '{st: P_IDLE, method: flash_status_pkg::M_IDLE, erase: 1'b0, addr: 21'h00_0000,
                     expect_d: 8'h00, last: 8'h00, result: 8'h00, busy: 1'b0, done: 1'b0,
                     fail: 1'b0, susp: 1'b0, window: 1'b0, rb: 1'b1, go: 1'b0, ahb_wr: 1'b0,
                     ahb_addr: 8'h00, rdata: 32'h0000_0000};
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ============================================================
  // outputs, from flip-flops or tied constants
  assign hrdata_o    = state_reg.rdata;
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;
  assign ce_n_o      = rd_ce_n;
  assign oe_n_o      = rd_oe_n;
  assign we_n_o      = 1'b1;
  assign addr_o      = state_reg.addr;
endmodule : flash_status_poller

//--- testbench/flash_status_poller_asserts.sv
// port checker for the flash status poller
module flash_status_poller_asserts #(
  parameter int RD_CYC  = 2,
  parameter int GAP_CYC = 1
) (
  // clock and reset
  input wire logic        mclk_i,
  input wire logic        rst_n_i,
  // ahb-lite
  input wire logic        hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic        hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic        hreadyout_o,
  input wire logic        hresp_o,
  // flash pins
  input wire logic        ce_n_o,
  input wire logic        oe_n_o,
  input wire logic        we_n_o,
  input wire logic [20:0] addr_o
);
  // ============================================================
  // strobe low and high cycle counters
  logic [7:0] lo_cnt_reg;
  logic [7:0] hi_cnt_reg;
  logic       taken;
  assign taken = hsel_i & hready_i & htrans_i[1];
  // high count saturates so a long idle cannot wrap
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      lo_cnt_reg <= 8'h00;
      hi_cnt_reg <= 8'h00;
    end
    else
    begin
      lo_cnt_reg <= oe_n_o ? 8'h00 : lo_cnt_reg + 8'h01;
      hi_cnt_reg <= !oe_n_o ? 8'h00 : ((hi_cnt_reg == 8'hFF) ? hi_cnt_reg : hi_cnt_reg + 8'h01);
    end
  end
  // ============================================================
  // assertions
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);
  property p_okay;
    hreadyout_o && !hresp_o;
  endproperty
  a_okay: assert property (p_okay) else $error("slave not ready or not okay");
  property p_no_write;
    we_n_o;
  endproperty
  a_no_write: assert property (p_no_write) else $error("write strobe driven");
  property p_strobe_len;
    $rose(oe_n_o) |-> int'(lo_cnt_reg) == RD_CYC;
  endproperty
  a_strobe_len: assert property (p_strobe_len) else $error("read strobe length wrong");
  property p_gap;
    $fell(oe_n_o) |-> int'(hi_cnt_reg) >= GAP_CYC;
  endproperty
  a_gap: assert property (p_gap) else $error("reads merged without gap");
  property p_ce_oe;
    ce_n_o == oe_n_o;
  endproperty
  a_ce_oe: assert property (p_ce_oe) else $error("strobes differ");
  property p_addr_hold;
    !oe_n_o && !$past(oe_n_o) |-> $stable(addr_o);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved in read");
  property p_unmapped;
    taken && !hwrite_i && haddr_i > 32'h0000_0013 && haddr_i < 32'h0000_0100 |=> hrdata_o == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_rdata_stands;
    $changed(hrdata_o) |-> $past(taken);
  endproperty
  a_rdata_stands: assert property (p_rdata_stands) else $error("read data moved unasked");
  // main scenarios
  c_read: cover property ($rose(oe_n_o));
  c_status: cover property (taken && !hwrite_i && haddr_i == 32'h0000_000C);
  c_start: cover property (taken && hwrite_i && haddr_i == 32'h0000_0000);
endmodule : flash_status_poller_asserts

bind flash_status_poller flash_status_poller_asserts #(.RD_CYC(RD_CYC), .GAP_CYC(GAP_CYC)) chk_u (
  .mclk_i(mclk_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
  .hwrite_i(hwrite_i), .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
  .hresp_o(hresp_o), .ce_n_o(ce_n_o), .oe_n_o(oe_n_o), .we_n_o(we_n_o), .addr_o(addr_o));

//--- testbench/flash_status_model.sv
// behavioural flash device answering status reads
module flash_status_model (
  // strobes and address
  input  wire logic        ce_n_i,
  input  wire logic        oe_n_i,
  input  wire logic [20:0] addr_i,
  // operation set up by the bench
  input  wire logic        cmd_i,
  input  wire logic        erase_i,
  input  wire logic        susp_i,
  input  wire logic        fail_i,
  input  wire logic [7:0]  len_i,
  input  wire logic [7:0]  pd_i,
  input  wire logic [20:0] pa_i,
  // data and open-drain ready pin
  output logic [7:0]       dq_o,
  output wire              ready_busy_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] n_rd_reg = 8'h00;
  logic       tog1_reg = 1'b0;
  logic       tog2_reg = 1'b0;
  logic [7:0] last_reg = 8'h00;
  logic [7:0] stat;
  logic [7:0] val;
  logic       rd_n;
  logic       esus;
  logic       busy;
  logic       hit;
  // a read ends when either strobe rises
  assign rd_n = ce_n_i | oe_n_i;
  assign esus = susp_i & erase_i;
  // busy from the command until len reads pass, or for good on a timeout; never busy in an erase suspend
  assign busy = cmd_i & ((n_rd_reg < len_i) | fail_i) & !esus;
  assign ready_busy_n_o = busy ? 1'b0 : 1'bz;
  // status only at the program address or inside the erased sector
  assign hit = erase_i ? (addr_i[20:16] == pa_i[20:16]) : (addr_i == pa_i);
  assign stat = erase_i ? {esus, tog1_reg, fail_i, 2'b01, tog2_reg, 2'b00}
                        : {~pd_i[7], tog1_reg, fail_i, 5'b00000};
  assign val = (cmd_i & (busy | esus) & hit) ? stat : pd_i;
  // a released bus shows the inverse of the last byte
  assign dq_o = rd_n ? ~last_reg : val;
  // count reads and advance toggles once per finished read
  always @(posedge rd_n or negedge cmd_i)
  begin
    if (!cmd_i)
      n_rd_reg <= 8'h00;
    else
    begin
      n_rd_reg <= n_rd_reg + 8'h01;
      tog1_reg <= busy ? ~tog1_reg : tog1_reg;
      tog2_reg <= (erase_i & hit) ? ~tog2_reg : tog2_reg;
      last_reg <= val;
    end
  end
endmodule : flash_status_model

//--- testbench/testbench.sv
// self-checking bench for the flash status poller
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RD    = 2;
  localparam int GAP   = 1;
  localparam int LIMIT = 40000;
  logic        mclk;
  logic        rst_n;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic        ce_n;
  logic        oe_n;
  logic        we_n;
  logic [20:0] faddr;
  logic [7:0]  dq;
  tri1         rb_w;
  logic        m_cmd, m_erase, m_susp, m_fail;
  logic [7:0]  m_len, m_pd;
  logic [20:0] m_pa;
  int          n_mismatch = 0;
  int          total_checks = 0;
  int          cycles = 0;
  // ============================================================
  // design and device model
  flash_status_poller #(.RD_CYC(RD), .GAP_CYC(GAP)) dut_u (
    .mclk_i(mclk), .rst_n_i(rst_n), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(hresp), .ce_n_o(ce_n), .oe_n_o(oe_n), .we_n_o(we_n),
    .addr_o(faddr), .dq_i(dq), .ready_busy_n_i(rb_w));
  flash_status_model model_u (
    .ce_n_i(ce_n), .oe_n_i(oe_n), .addr_i(faddr), .cmd_i(m_cmd), .erase_i(m_erase),
    .susp_i(m_susp), .fail_i(m_fail), .len_i(m_len), .pd_i(m_pd), .pa_i(m_pa),
    .dq_o(dq), .ready_busy_n_o(rb_w));
  // ============================================================
  // clock and hang guard
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      n_mismatch++;
      print_verdict();
    end
  end
  // ============================================================
  // tasks
  task automatic print_verdict();
    if (n_mismatch == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one single ahb-lite transfer, waiting on hready in both phases
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    htrans <= 2'b10;
    haddr  <= {24'h00_0000, a};
    hwrite <= wr;
    @(posedge mclk);
    while (hready !== 1'b1) @(posedge mclk);
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge mclk);
    while (hready !== 1'b1) @(posedge mclk);
    rd = hrdata;
  endtask : ahb
  // one status-polling operation against the model
  task automatic run_op(input logic er, input logic su, input logic fl, input logic tg,
                        input logic [7:0] n, input logic [7:0] pd, input logic [20:0] pa);
    logic [31:0] st;
    logic [31:0] res;
    logic [20:0] ra;
    ra = er ? {pa[20:16], 16'h7FF0} : pa;
    m_erase <= er;
    m_susp  <= su;
    m_fail  <= fl;
    m_len   <= n;
    m_pd    <= pd;
    m_pa    <= pa;
    m_cmd   <= 1'b1;
    ahb(1'b1, 8'h04, {11'h000, ra}, st);
    ahb(1'b1, 8'h08, {24'h00_0000, pd}, st);
    ahb(1'b1, 8'h00, {29'h0000_0000, tg, er, 1'b1}, st);
    ahb(1'b0, 8'h0C, 32'h0000_0000, st);
    if (n > 8'h02) check({31'h0, st[4]}, {31'h0, su & er});
    check({11'h000, faddr}, {11'h000, ra});
    while (st[0] !== 1'b0) ahb(1'b0, 8'h0C, 32'h0000_0000, st);
    ahb(1'b0, 8'h10, 32'h0000_0000, res);
    check({31'h0, st[2]}, {31'h0, fl});
    if (!fl && !(su && er)) check({24'h00_0000, res[7:0]}, {24'h00_0000, pd});
    if (su && er) check({31'h0, res[7]}, 32'h0000_0001);
    if (su && er && tg) check({31'h0, st[3]}, 32'h0000_0001);
    if (!fl) check({31'h0, st[4]}, 32'h0000_0001);
    if (er) check({31'h0, st[5]}, 32'h0000_0001);
    m_cmd <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask : run_op
  // ============================================================
  // main sequence
  initial
  begin
    logic [31:0] d;
    {hsel, haddr, htrans, hwrite, hwdata, rst_n} = '0;
    {m_cmd, m_erase, m_susp, m_fail, m_len, m_pd, m_pa} = '0;
    hsize = 3'b010;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    hsel  <= 1'b1;
    @(posedge mclk);
    ahb(1'b0, 8'h0C, 32'h0000_0000, d);
    check({29'h0000_0000, d[2:0]}, 32'h0000_0000);
    check({31'h0, d[4]}, 32'h0000_0001);
    ahb(1'b0, 8'h40, 32'h0000_0000, d);
    check(d, 32'h0000_0000);
    // erase, suspend, fail, toggle, reads busy, data, address
    run_op(1'b0, 1'b0, 1'b0, 1'b0, 8'h03, 8'hA5, 21'h1_2345);
    run_op(1'b0, 1'b0, 1'b0, 1'b1, 8'h04, 8'h3C, 21'h0_0F00);
    run_op(1'b1, 1'b0, 1'b0, 1'b0, 8'h05, 8'hFF, 21'h1_A000);
    run_op(1'b1, 1'b0, 1'b0, 1'b1, 8'h03, 8'hFF, 21'h1_F000);
    run_op(1'b0, 1'b0, 1'b0, 1'b1, 8'h02, 8'h5A, 21'h0_0010);
    run_op(1'b1, 1'b0, 1'b0, 1'b0, 8'h20, 8'hFF, 21'h0_3000);
    run_op(1'b1, 1'b1, 1'b0, 1'b1, 8'h03, 8'h77, 21'h0_5000);
    run_op(1'b1, 1'b1, 1'b0, 1'b0, 8'h03, 8'h77, 21'h0_6000);
    run_op(1'b0, 1'b1, 1'b0, 1'b0, 8'h03, 8'hC3, 21'h0_7000);
    run_op(1'b0, 1'b0, 1'b1, 1'b0, 8'h03, 8'h81, 21'h0_8000);
    run_op(1'b1, 1'b0, 1'b1, 1'b1, 8'h03, 8'hFF, 21'h0_9000);
    print_verdict();
  end
endmodule : testbench
